// ==== hw/autoneg_next_page_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module autoneg_next_page_regs
    import anp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Arbitration side, transmit
    input wire logic np_restart,
    input wire logic tx_page_req,
    input wire logic local_ack,
    output logic [15:0] tx_page_word,
    output logic tx_page_valid,
    // Arbitration side, receive
    input wire logic rx_page_valid,
    input wire logic [15:0] rx_page_word,
    output logic page_received
);
    initial begin
        if (ADDR_W < 6 || ADDR_W > 32) begin
            $error("autoneg_next_page_regs: ADDR_W must be 6..32");
        end
    end

    // Field map must tile the 16-bit page word
    initial begin
        if (CODE_W != CODE_MSB + 1 || BIT_TOG != CODE_MSB + 1) begin
            $error("autoneg_next_page_regs: code field must end below the toggle bit");
        end
        if (BIT_MORE != 15 || BIT_ACK != 14 || BIT_TYPE != 13 || BIT_CACK != 12) begin
            $error("autoneg_next_page_regs: flag bits out of place");
        end
        if (NULL_PAGE[CODE_MSB:0] != CODE_RESET) begin
            $error("autoneg_next_page_regs: null page code must equal the code reset value");
        end
    end

    // Bus decode
    logic [5:0] idx;
    logic aligned;
    logic upper_zero;
    logic hit_exp;
    logic hit_tx;
    logic hit_rx;
    logic mapped;
    logic acc_start;
    logic acc_done;
    logic wr_done;
    logic rd_done;

    // Register state
    logic more_q;
    logic ack_q;
    logic type_q;
    logic cack_q;
    logic tog_q;
    logic [CODE_W-1:0] code_q;
    logic page_rx_q;
    logic local_done_q;
    logic [15:0] rx_word_q;
    logic [15:0] tx_reg_view;
    logic [15:0] exp_view;
    logic [15:0] rd_mux;

    // Outgoing word
    logic [15:0] tx_word_d;
    logic [15:0] tx_word_q;
    logic tx_valid_q;
    logic send;

    // Bus handshake state
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    always_comb begin
        idx = 6'h00;
        upper_zero = 1'b1;
        for (int i = 2; i < ADDR_W; i++) begin
            if (i < 8) begin
                idx[i-2] = paddr[i];
            end else if (paddr[i]) begin
                upper_zero = 1'b0;
            end
        end
    end

    assign aligned = (paddr[1:0] == 2'b00);
    assign hit_exp = aligned && upper_zero && (idx == IDX_EXPANSION);
    assign hit_tx = aligned && upper_zero && (idx == IDX_NP_TX);
    assign hit_rx = aligned && upper_zero && (idx == IDX_NP_RX);
    assign mapped = hit_exp || hit_tx || hit_rx;

    // Access phase takes two cycles: wait state, then pready
    assign acc_start = psel && penable && !pready_q;
    assign acc_done = psel && penable && pready_q;
    assign wr_done = acc_done && pwrite;
    assign rd_done = acc_done && !pwrite;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= acc_start;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= acc_start && !mapped;
        end
    end

    // Read data sampled with the wait state so it stands with pready
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (acc_start && !pwrite) begin
            prdata_q <= {16'h0000, rd_mux};
        end else if (!psel) begin
            prdata_q <= 32'h0000_0000;
        end
    end

    always_comb begin
        tx_reg_view = 16'h0000;
        tx_reg_view[BIT_MORE] = more_q;
        tx_reg_view[BIT_ACK] = ack_q;
        tx_reg_view[BIT_TYPE] = type_q;
        tx_reg_view[BIT_CACK] = cack_q;
        tx_reg_view[BIT_TOG] = tog_q;
        tx_reg_view[CODE_MSB:0] = code_q;
    end

    // Storage location is fixed at register 8
    always_comb begin
        exp_view = 16'h0000;
        exp_view[EXP_LOC_ABLE] = 1'b1;
        exp_view[EXP_STOR_LOC] = 1'b1;
        exp_view[EXP_NP_ABLE] = 1'b1;
        exp_view[EXP_PAGE_RX] = page_rx_q;
    end

    always_comb begin
        if (hit_tx) begin
            rd_mux = tx_reg_view;
        end else if (hit_rx) begin
            rd_mux = rx_word_q;
        end else if (hit_exp) begin
            rd_mux = exp_view;
        end else begin
            rd_mux = 16'h0000;
        end
    end

    // Software fields of the transmit register; acknowledge and toggle are not writable
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            more_q <= NP_TX_RESET[BIT_MORE];
        end else if (wr_done && hit_tx && pstrb[1]) begin
            more_q <= pwdata[BIT_MORE];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            type_q <= NP_TX_RESET[BIT_TYPE];
        end else if (wr_done && hit_tx && pstrb[1]) begin
            type_q <= pwdata[BIT_TYPE];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cack_q <= NP_TX_RESET[BIT_CACK];
        end else if (wr_done && hit_tx && pstrb[1]) begin
            cack_q <= pwdata[BIT_CACK];
        end
    end

    // Code is taken as is; page type only decides how the partner reads it
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            code_q <= CODE_RESET;
        end else if (wr_done && hit_tx) begin
            if (pstrb[0]) begin
                code_q[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                code_q[CODE_MSB:8] <= pwdata[CODE_MSB:8];
            end
        end
    end

    // Acknowledge follows the arbitration's level
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ack_q <= NP_TX_RESET[BIT_ACK];
        end else begin
            ack_q <= local_ack;
        end
    end

    // Each sent word carries tog_q, then it flips: reads the inverse of the last one
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tog_q <= NP_TX_RESET[BIT_TOG];
        end else if (np_restart) begin
            tog_q <= NP_TX_RESET[BIT_TOG];
        end else if (send) begin
            tog_q <= ~tog_q;
        end
    end

    // Once a page with more-pages clear has gone, only null pages follow until np_restart
    assign send = tx_page_req && !np_restart;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            local_done_q <= 1'b0;
        end else if (np_restart) begin
            local_done_q <= 1'b0;
        end else if (send && !local_done_q && !more_q) begin
            local_done_q <= 1'b1;
        end
    end

    always_comb begin
        if (local_done_q) begin
            tx_word_d = NULL_PAGE;
            tx_word_d[BIT_MORE] = 1'b0;
        end else begin
            tx_word_d = tx_reg_view;
        end
        tx_word_d[BIT_ACK] = ack_q;
        tx_word_d[BIT_TOG] = tog_q;
    end

    page_word_reg #(
        .W(16),
        .RESET_VAL(NULL_PAGE)
    ) u_tx_word (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(send),
        .d(tx_word_d),
        .q(tx_word_q)
    );

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_valid_q <= 1'b0;
        end else begin
            tx_valid_q <= send;
        end
    end

    // Partner words are held whole, including its toggle
    page_word_reg #(
        .W(16),
        .RESET_VAL(NP_RX_RESET)
    ) u_rx_word (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(rx_page_valid),
        .d(rx_page_word),
        .q(rx_word_q)
    );

    // New word beats a read clear in the same cycle
    // Clear only a set the read returned; one landing after the data sample survives
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            page_rx_q <= 1'b0;
        end else if (rx_page_valid) begin
            page_rx_q <= 1'b1;
        end else if (rd_done && hit_exp && prdata_q[EXP_PAGE_RX]) begin
            page_rx_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign tx_page_word = tx_word_q;
    assign tx_page_valid = tx_valid_q;
    assign page_received = page_rx_q;
endmodule : autoneg_next_page_regs
`default_nettype wire

// ==== hw/anp_pkg.sv ====
package anp_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_EXPANSION = 6'h06;
    localparam logic [5:0] IDX_NP_TX = 6'h07;
    localparam logic [5:0] IDX_NP_RX = 6'h08;
    // Page word field positions
    localparam int BIT_MORE = 15;
    localparam int BIT_ACK = 14;
    localparam int BIT_TYPE = 13;
    localparam int BIT_CACK = 12;
    localparam int BIT_TOG = 11;
    localparam int CODE_MSB = 10;
    localparam int CODE_W = 11;
    // Reset values
    localparam logic [15:0] NP_TX_RESET = 16'h2001;
    localparam logic [15:0] NP_RX_RESET = 16'h2001;
    localparam logic [15:0] NULL_PAGE = 16'h2001;
    localparam logic [10:0] CODE_RESET = 11'h001;
    // Expansion status bit positions
    localparam int EXP_LOC_ABLE = 6;
    localparam int EXP_STOR_LOC = 5;
    localparam int EXP_NP_ABLE = 2;
    localparam int EXP_PAGE_RX = 1;
endpackage : anp_pkg

// ==== hw/page_word_reg.sv ====
`timescale 1ns/1ps
`default_nettype none
module page_word_reg
    import anp_pkg::*;
#(
    parameter int W = 16,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Load port
    input wire logic load,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    initial begin
        if (W < 1) begin
            $error("page_word_reg: W must be positive");
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q <= RESET_VAL;
        end else if (load) begin
            q <= d;
        end
    end
endmodule : page_word_reg
`default_nettype wire

// ==== tb/anp_checks_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module anp_checks
    import anp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock, reset, APB
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    // Page exchange
    input wire logic np_restart,
    input wire logic tx_page_req,
    input wire logic [15:0] tx_page_word,
    input wire logic tx_page_valid,
    input wire logic rx_page_valid,
    input wire logic page_received
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic done_q;
    always_ff @(posedge mclk) begin
        if (!rst_n || np_restart) begin
            done_q <= 1'b0;
        end else if (tx_page_valid && !tx_page_word[15]) begin
            done_q <= 1'b1;
        end
    end
    wait_state_a: assert property (psel && penable && !pready |=> pready) else $error("late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("long");
    err_ready_a: assert property (pslverr |-> pready) else $error("err");
    tx_answer_a: assert property (tx_page_req && !np_restart |=> tx_page_valid) else $error("tx");
    tx_cause_a: assert property (tx_page_valid |-> $past(tx_page_req) && !$past(np_restart)) else $error("tx");
    word_hold_a: assert property ($past(rst_n) && !tx_page_valid |-> $stable(tx_page_word)) else $error("w");
    null_after_a: assert property (tx_page_valid && done_q |-> tx_page_word[15:12] ==? 4'b0?10
        && tx_page_word[10:0] == CODE_RESET) else $error("null");
    rx_set_a: assert property (rx_page_valid |=> page_received) else $error("rx");
    rx_clear_a: assert property ($past(rst_n) && $fell(page_received) |-> $past(psel) && $past(pready)
        && !$past(pwrite) && $past(paddr) == ADDR_W'({IDX_EXPANSION, 2'b00})) else $error("clr");
endmodule : anp_checks
bind autoneg_next_page_regs anp_checks #(.ADDR_W(ADDR_W)) anp_checks_inst (
    .mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .np_restart(np_restart), .tx_page_req(tx_page_req),
    .tx_page_word(tx_page_word), .tx_page_valid(tx_page_valid), .rx_page_valid(rx_page_valid),
    .page_received(page_received)
);
`default_nettype wire

// ==== tb/link_partner_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Our page and the reply it provokes
    input wire logic tx_page_valid,
    input wire logic [2:0] lag,
    input wire logic [15:0] lp_word,
    // Partner page
    output logic rx_page_valid,
    output logic [15:0] rx_page_word
);
    logic [2:0] wait_q;
    logic [15:0] held_q;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wait_q <= 3'h0;
        end else if (tx_page_valid) begin
            wait_q <= lag;
            held_q <= {lp_word[15], 1'b1, lp_word[13:0]};
        end else if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
        end
    end
    // Word churns between pages so a stale capture shows
    always_ff @(posedge mclk) begin
        rx_page_valid <= rst_n && wait_q == 3'h1;
        rx_page_word <= !rst_n ? 16'h5a5a : (wait_q == 3'h1) ? held_q : ~rx_page_word;
    end
endmodule : link_partner_model
`default_nettype wire

// ==== tb/test_autoneg_next_page_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_autoneg_next_page_regs import anp_pkg::*; ;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic np_restart = 1'b0, tx_page_req = 1'b0, local_ack = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [2:0] lag = 3'h1;
    logic [15:0] lp_word = 16'h0000;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr, tx_page_valid, rx_page_valid, page_received;
    logic [15:0] tx_page_word, rx_page_word;
    logic [31:0] seed = 32'h00017d2b;
    int bad_count = 0;
    int n_tests = 0;
    initial begin
        forever #5 mclk = ~mclk;
    end
    autoneg_next_page_regs #(.ADDR_W(8)) autoneg_next_page_regs_inst (
        .mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .np_restart(np_restart), .tx_page_req(tx_page_req), .local_ack(local_ack),
        .tx_page_word(tx_page_word), .tx_page_valid(tx_page_valid), .rx_page_valid(rx_page_valid),
        .rx_page_word(rx_page_word), .page_received(page_received)
    );
    link_partner_model link_partner_model_inst (
        .mclk(mclk), .rst_n(rst_n), .tx_page_valid(tx_page_valid), .lag(lag), .lp_word(lp_word),
        .rx_page_valid(rx_page_valid), .rx_page_word(rx_page_word)
    );
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [31:0] page_exp(logic [15:0] w, logic ack, logic tog, logic done);
        // Out of pages: null pages only
        if (done) begin
            w = NULL_PAGE;
        end
        return {16'h0000, w[15], ack, w[13:12], tog, w[10:0]};
    endfunction : page_exp
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd, logic [3:0] st);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic rd_chk(string what, logic [7:0] a, logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(what, exp, rdat);
    endtask : rd_chk
    task give_verdict();
        if (bad_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        give_verdict();
    end
    initial begin
        logic [15:0] cur;
        logic [31:0] r;
        logic tog;
        logic done;
        cur = NP_TX_RESET;
        tog = 1'b0;
        done = 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd_chk("exp", 8'h18, 32'h64);
        rd_chk("tx rst", 8'h1c, 32'h2001);
        rd_chk("rx rst", 8'h20, 32'h2001);
        apb(1'b1, 8'h20, 32'hffff_ffff, 4'hf);
        rd_chk("rx ro", 8'h20, 32'h2001);
        apb(1'b0, 8'h44, 32'h0, 4'h0);
        chk("unmapped", 32'h1, {31'h0, rerr});
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            if (i == 12) begin
                np_restart <= 1'b1;
                @(posedge mclk);
                np_restart <= 1'b0;
                tog = 1'b0;
                done = 1'b0;
            end
            local_ack <= r[20];
            lag <= {1'b0, r[22:21]} + 3'h1;
            lp_word <= r[31:16];
            apb(1'b1, 8'h1c, r, r[27:24]);
            cur[7:0] = r[24] ? r[7:0] : cur[7:0];
            cur[15:8] = r[25] ? r[15:8] : cur[15:8];
            rd_chk("tx reg", 8'h1c, page_exp(cur, r[20], tog, 1'b0));
            tx_page_req <= 1'b1;
            @(posedge mclk);
            tx_page_req <= 1'b0;
            @(posedge mclk);
            chk("tx valid", 32'h1, {31'h0, tx_page_valid});
            chk("tx word", page_exp(cur, r[20], tog, done), {16'h0, tx_page_word});
            done = done | !cur[15];
            tog = !tog;
            while (page_received !== 1'b1) begin
                @(posedge mclk);
            end
            rd_chk("rx reg", 8'h20, {16'h0, r[31], 1'b1, r[29:16]});
            rd_chk("rx set", 8'h18, 32'h66);
            rd_chk("rx clr", 8'h18, 32'h64);
        end
        give_verdict();
    end
endmodule : test_autoneg_next_page_regs
`default_nettype wire
